// ==== jbs_pkg.sv ====
// shared constants, encodings and carrier types of the boundary scan test port
package jbs_pkg;

  localparam int IR_W        = 6;
  localparam int ID_W        = 32;
  localparam int BSR_LEN     = 161;
  localparam int VER_MSB     = 31;
  localparam int VER_LSB     = 28;
  localparam int FAM_MSB     = 27;
  localparam int FAM_LSB     = 12;
  localparam int MFR_MSB     = 11;
  localparam int MFR_LSB     = 1;
  localparam int SYNC_STAGES = 2;

  localparam logic [IR_W-1:0] OP_EXTEST   = 6'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE   = 6'h01;
  localparam logic [IR_W-1:0] OP_CLAMP    = 6'h02;
  localparam logic [IR_W-1:0] OP_HIGHZ    = 6'h05;
  localparam logic [IR_W-1:0] OP_IDCODE   = 6'h20;
  localparam logic [IR_W-1:0] OP_USERCODE = 6'h25;
  localparam logic [IR_W-1:0] OP_BYPASS   = 6'h3F;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 6'h01;
  localparam logic            ID_LSB_ONE  = 1'h1;
  localparam logic            BYP_CAPTURE = 1'h0;

  typedef enum logic [3:0] {
    ST_TLR    = 4'hF,
    ST_RTI    = 4'hC,
    ST_SEL_DR = 4'h7,
    ST_CAP_DR = 4'h6,
    ST_SH_DR  = 4'h2,
    ST_EX1_DR = 4'h1,
    ST_PAU_DR = 4'h3,
    ST_EX2_DR = 4'h0,
    ST_UPD_DR = 4'h5,
    ST_SEL_IR = 4'h4,
    ST_CAP_IR = 4'hE,
    ST_SH_IR  = 4'hA,
    ST_EX1_IR = 4'h9,
    ST_PAU_IR = 4'hB,
    ST_EX2_IR = 4'h8,
    ST_UPD_IR = 4'hD
  } jbs_state_t;

  typedef enum logic [2:0] {
    IN_EXTEST = 3'h0,
    IN_SAMPLE = 3'h1,
    IN_IDCODE = 3'h2,
    IN_USER   = 3'h3,
    IN_CLAMP  = 3'h4,
    IN_HIGHZ  = 3'h5,
    IN_BYPASS = 3'h6
  } jbs_instr_t;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } jbs_dr_ctl_t;

  typedef struct packed {
    logic drive;
    logic highz;
    logic sel_bsr;
    logic sel_id;
  } jbs_mode_t;

endpackage

// ==== jbs_bsr.sv ====
// boundary scan register: capture/shift stages and update latches
`timescale 1ns/10ps
module jbs_bsr
  import jbs_pkg::*;
#(
  parameter int LEN = BSR_LEN
) (
  input  wire logic           tck,
  input  wire logic           trst_n,
  input  wire logic           en,
  input  wire jbs_dr_ctl_t    ctl,
  input  wire logic           sel,
  input  wire logic           tdi,
  input  wire logic [LEN-1:0] cap_vec,
  output logic                so,
  output logic      [LEN-1:0] upd_vec
);

  logic [LEN-1:0] shift_r;
  logic [LEN-1:0] shift_nxt;
  logic [LEN-1:0] upd_r;

  // capture snapshots every cell, shift moves toward cell 0
  assign shift_nxt = ctl.capture ? cap_vec : {tdi, shift_r[LEN-1:1]};

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      shift_r <= '0;
    end else if (en && sel && (ctl.capture || ctl.shift)) begin
      shift_r <= shift_nxt;
    end
  end

  // update latches hold still while unselected, so clamp freezes the pins
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      upd_r <= '0;
    end else if (en && sel && ctl.update) begin
      upd_r <= shift_r;
    end
  end

  assign so      = shift_r[0];
  assign upd_vec = upd_r;

endmodule

// ==== jbs_tap.sv ====
// test access port controller, instruction decode, data registers and pin muxing
//
// Contract
// - bypass code places a single stage between tdi and tdo.
// - clamp drives pins from scan latches unchanged, bypass stage forms serial path.
// - extest selects 161 cells, samples inputs, drives outputs from cells.
// - highz releases every system output, bypass stage forms serial path.
// - idcode shifts 32-bit word: version, family, manufacturer, bit 0 one.
// - usercode shifts separate word, same layout, part number, different version.
// - sample/preload snapshots pins undisturbed and lets new cell values shift in.
// - every pin observed by a cell; outputs driven; bidirs get in/out/control cells.
// - tap reset or no new instruction loads idcode; id register then selected.
// - undefined instruction codes decode as bypass.
// - pins tms, tck, tdi, tdo plus optional asynchronous trst.
`timescale 1ns/10ps
module jbs_tap
  import jbs_pkg::*;
#(
  parameter int              N_IN        = 40,
  parameter int              N_OUT       = 40,
  parameter int              N_BIDIR     = 27,
  parameter logic [3:0]      ID_VERSION  = 4'h2,     // arbitrary
  parameter logic [3:0]      USR_VERSION = 4'h3,     // arbitrary
  parameter logic [15:0]     FAMILY_ID   = 16'h5A3C, // arbitrary
  parameter logic [15:0]     PART_NUM    = 16'h5A3C, // arbitrary
  parameter logic [10:0]     MFR_ID      = 11'h2A6   // arbitrary
) (
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire logic               tck,
  input  wire logic               trst_n,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe_n,
  input  wire logic [N_IN-1:0]    pin_in,
  output logic      [N_IN-1:0]    core_in,
  input  wire logic [N_OUT-1:0]   core_out,
  output logic      [N_OUT-1:0]   pin_out,
  output logic      [N_OUT-1:0]   pin_out_oe_n,
  input  wire logic [N_BIDIR-1:0] core_bd_o,
  input  wire logic [N_BIDIR-1:0] core_bd_oe_n,
  output logic      [N_BIDIR-1:0] core_bd_i,
  input  wire logic [N_BIDIR-1:0] pin_bd_i,
  output logic      [N_BIDIR-1:0] pin_bd_o,
  output logic      [N_BIDIR-1:0] pin_bd_oe_n,
  output logic                    test_hold
);

  localparam int OUT_BASE = N_IN;
  localparam int BD_BASE  = N_IN + N_OUT;
  localparam int LEN      = N_IN + N_OUT + 3 * N_BIDIR;

  if (LEN != BSR_LEN) begin : g_len_chk
    $error("boundary cell count does not match the scan chain length");
  end
  if (ID_VERSION == USR_VERSION) begin : g_ver_chk
    $error("usercode version must differ from idcode version");
  end

  function automatic jbs_instr_t instr_dec(input logic [IR_W-1:0] code);
    case (code)
      OP_EXTEST:   instr_dec = IN_EXTEST;
      OP_SAMPLE:   instr_dec = IN_SAMPLE;
      OP_IDCODE:   instr_dec = IN_IDCODE;
      OP_USERCODE: instr_dec = IN_USER;
      OP_CLAMP:    instr_dec = IN_CLAMP;
      OP_HIGHZ:    instr_dec = IN_HIGHZ;
      default:     instr_dec = IN_BYPASS;
    endcase
  endfunction

  function automatic jbs_state_t tap_next(input jbs_state_t s, input logic m);
    case (s)
      ST_TLR:    tap_next = m ? ST_TLR    : ST_RTI;
      ST_RTI:    tap_next = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: tap_next = m ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
      default:   tap_next = ST_TLR;
    endcase
  endfunction

  // clock enable crosses into the tck domain as a level
  logic [SYNC_STAGES-1:0] en_sync_r;
  logic                   tck_en;

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      en_sync_r <= '0;
    end else begin
      en_sync_r <= {en_sync_r[SYNC_STAGES-2:0], clk_en};
    end
  end
  assign tck_en = en_sync_r[SYNC_STAGES-1];

  jbs_state_t state_r;
  jbs_state_t state_nxt;

  assign state_nxt = tap_next(state_r, tms);

  // trst acts at once, without tck
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state_r <= ST_TLR;
    end else if (tck_en) begin
      state_r <= state_nxt;
    end
  end

  wire sh_ir  = (state_r == ST_SH_IR);
  wire cap_ir = (state_r == ST_CAP_IR);
  wire upd_ir = (state_r == ST_UPD_IR);
  wire sh_dr  = (state_r == ST_SH_DR);

  jbs_dr_ctl_t dr_ctl;
  assign dr_ctl.capture = (state_r == ST_CAP_DR);
  assign dr_ctl.shift   = sh_dr;
  assign dr_ctl.update  = (state_r == ST_UPD_DR);

  logic [IR_W-1:0] ir_sh_r;
  logic [IR_W-1:0] ir_r;
  logic            ir_new_r;

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh_r  <= IR_CAPTURE;
      ir_new_r <= 1'b0;
    end else if (tck_en) begin
      if (cap_ir) begin
        ir_sh_r  <= IR_CAPTURE;
        ir_new_r <= 1'b0;
      end else if (sh_ir) begin
        ir_sh_r  <= {tdi, ir_sh_r[IR_W-1:1]};
        ir_new_r <= 1'b1;
      end
    end
  end

  // a full code is always present, so no half-shifted bits reach the decode
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_r <= OP_IDCODE;
    end else if (tck_en) begin
      if (state_r == ST_TLR) begin
        ir_r <= OP_IDCODE;
      end else if (upd_ir) begin
        ir_r <= ir_new_r ? ir_sh_r : OP_IDCODE;
      end
    end
  end

  jbs_instr_t instr;
  jbs_mode_t  mode;

  assign instr        = instr_dec(ir_r);
  assign mode.drive   = (instr == IN_EXTEST) || (instr == IN_CLAMP);
  assign mode.highz   = (instr == IN_HIGHZ);
  assign mode.sel_bsr = (instr == IN_EXTEST) || (instr == IN_SAMPLE);
  assign mode.sel_id  = (instr == IN_IDCODE) || (instr == IN_USER);

  wire [ID_W-1:0] id_word  = {ID_VERSION, FAMILY_ID, MFR_ID, ID_LSB_ONE};
  wire [ID_W-1:0] usr_word = {USR_VERSION, PART_NUM, MFR_ID, ID_LSB_ONE};

  logic [ID_W-1:0] id_sh_r;
  logic            byp_r;

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      id_sh_r <= '0;
    end else if (tck_en && mode.sel_id) begin
      if (dr_ctl.capture) begin
        id_sh_r <= (instr == IN_USER) ? usr_word : id_word;
      end else if (sh_dr) begin
        id_sh_r <= {tdi, id_sh_r[ID_W-1:1]};
      end
    end
  end

  // one stage: tdi bit appears at tdo one period later
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      byp_r <= BYP_CAPTURE;
    end else if (tck_en) begin
      if (dr_ctl.capture) begin
        byp_r <= BYP_CAPTURE;
      end else if (sh_dr) begin
        byp_r <= tdi;
      end
    end
  end

  logic [LEN-1:0] obs_raw;
  logic [LEN-1:0] obs_s1_r;
  logic [LEN-1:0] obs_s2_r;
  logic [LEN-1:0] upd_vec;
  logic           bsr_so;

  // pin and core levels are foreign to tck, so two stages before capture
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      obs_s1_r <= '0;
      obs_s2_r <= '0;
    end else begin
      obs_s1_r <= obs_raw;
      obs_s2_r <= obs_s1_r;
    end
  end

  jbs_bsr #(
    .LEN (LEN)
  ) u_bsr (
    .tck     (tck),
    .trst_n  (trst_n),
    .en      (tck_en),
    .ctl     (dr_ctl),
    .sel     (mode.sel_bsr),
    .tdi     (tdi),
    .cap_vec (obs_s2_r),
    .so      (bsr_so),
    .upd_vec (upd_vec)
  );

  // inputs reach the core untouched; extest only observes them
  assign core_in                  = pin_in;
  assign core_bd_i                = pin_bd_i;
  assign pin_out                  = mode.drive ? upd_vec[OUT_BASE +: N_OUT] : core_out;
  assign pin_out_oe_n             = {N_OUT{mode.highz}};
  assign obs_raw[N_IN-1:0]        = pin_in;
  assign obs_raw[OUT_BASE +: N_OUT] = pin_out;

  genvar gi;
  generate
    for (gi = 0; gi < N_BIDIR; gi++) begin : g_bidir
      localparam int B = BD_BASE + 3 * gi;
      assign pin_bd_o[gi]    = mode.drive ? upd_vec[B+1] : core_bd_o[gi];
      assign pin_bd_oe_n[gi] = mode.highz ? 1'b1 :
                               (mode.drive ? upd_vec[B+2] : core_bd_oe_n[gi]);
      assign obs_raw[B]      = pin_bd_i[gi];
      assign obs_raw[B+1]    = pin_bd_o[gi];
      assign obs_raw[B+2]    = pin_bd_oe_n[gi];
    end
  endgenerate

  wire sel_bit = sh_ir        ? ir_sh_r[0] :
                 mode.sel_bsr ? bsr_so :
                 mode.sel_id  ? id_sh_r[0] : byp_r;

  logic tdo_r;
  logic tdo_oe_n_r;

  // falling edge gives the tester half a period of settle time
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_r      <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else if (tck_en) begin
      tdo_r      <= sel_bit;
      tdo_oe_n_r <= !(sh_ir || sh_dr);
    end
  end

  assign tdo      = tdo_r;
  assign tdo_oe_n = tdo_oe_n_r;

  // core is told to stay quiet while the pins belong to the tester
  logic [SYNC_STAGES-1:0] hold_sync_r;
  logic                   test_hold_r;
  wire                    pins_taken = mode.drive || mode.highz;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_sync_r <= '0;
      test_hold_r <= 1'b0;
    end else if (clk_en) begin
      hold_sync_r <= {hold_sync_r[SYNC_STAGES-2:0], pins_taken};
      test_hold_r <= hold_sync_r[SYNC_STAGES-1];
    end
  end

  assign test_hold = test_hold_r;

endmodule

// ==== jbs_monitor.sv ====
// assertion checker on the boundary scan test port pins
`timescale 1ns/10ps
module jbs_monitor
  import jbs_pkg::*;
#(
  parameter int N_IN    = 40,
  parameter int N_OUT   = 40,
  parameter int N_BIDIR = 27
) (
  input wire logic               ref_clk,
  input wire logic               resetn,
  input wire logic               tck,
  input wire logic               trst_n,
  input wire logic               tms,
  input wire logic               tdo,
  input wire logic               tdo_oe_n,
  input wire logic [N_IN-1:0]    pin_in,
  input wire logic [N_IN-1:0]    core_in,
  input wire logic [N_OUT-1:0]   pin_out_oe_n,
  input wire logic [N_BIDIR-1:0] pin_bd_i,
  input wire logic [N_BIDIR-1:0] core_bd_i,
  input wire logic [N_BIDIR-1:0] pin_bd_oe_n,
  input wire logic               test_hold
);
  logic [2:0] ones_r;
  wire        all_hz = &pin_out_oe_n;
  // run of tms ones; two in a row already rule out any shift state
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ones_r <= 3'h0;
    end else if (!tms) begin
      ones_r <= 3'h0;
    end else if (ones_r != 3'h7) begin
      ones_r <= ones_r + 3'h1;
    end
  end
  chk_in_pass: assert property (@(posedge ref_clk) disable iff (!resetn)
    core_in == pin_in && core_bd_i == pin_bd_i) else $error("pin input not passed to core");
  chk_oe_uniform: assert property (@(posedge ref_clk) disable iff (!resetn)
    all_hz || pin_out_oe_n == '0) else $error("output enables split");
  chk_hz_bidir: assert property (@(posedge ref_clk) disable iff (!resetn)
    all_hz |-> &pin_bd_oe_n) else $error("bidir still driven in highz");
  chk_hz_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    all_hz |-> ##[0:8] test_hold) else $error("test hold missing in highz");
  chk_trst_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    !trst_n |-> tdo_oe_n && !tdo && !all_hz) else $error("tap reset not quiet");
  chk_shift_entry: assert property (@(posedge tck) disable iff (!trst_n)
    $fell(tdo_oe_n) |-> !$past(tms)) else $error("tdo enabled without shift entry");
  chk_shift_exit: assert property (@(posedge tck) disable iff (!trst_n)
    $rose(tdo_oe_n) |-> $past(tms)) else $error("tdo released without exit");
  chk_ones_idle: assert property (@(posedge tck) disable iff (!trst_n)
    ones_r >= 3'h2 |-> tdo_oe_n) else $error("tdo driven after tms ones");
  cov_highz: cover property (@(posedge ref_clk) disable iff (!resetn) all_hz && test_hold);
  cov_shift: cover property (@(posedge tck) disable iff (!trst_n) $fell(tdo_oe_n));
  cov_trst: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(trst_n));
endmodule

// ==== jbs_host_model.sv ====
// behavioural boundary scan tester driving the link pins
`timescale 1ns/10ps
module jbs_host_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  int   oe_err = 0;
  logic q_s;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 12 ns period; tck idles low between frames
  task automatic tick(input logic m, input logic d, input logic sh);
    #1;
    tms = m;
    tdi = sh ? d : ~tdi; // idle tdi toggles so a stale bit never looks valid
    #5;
    q_s = tdo;
    if (sh && tdo_oe_n !== 1'b0) oe_err++;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask
  // n of 0 goes from capture through exit1 to update without a shift, leaving no new instruction
  task automatic scan(input logic ir, input int n, input logic [199:0] din,
                      output logic [199:0] dout);
    dout = '0;
    tick(1'b1, 1'b0, 1'b0);
    if (ir) tick(1'b1, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0);
    tick(n == 0, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], 1'b1);
      dout[i] = q_s;
    end
    tick(1'b1, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0);
  endtask
  // extra ones cover the edges lost while the enable sync refills
  task automatic reset_tap();
    for (int i = 0; i < 8; i++) tick(1'b1, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0);
  endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the boundary scan test port
`timescale 1ns/10ps
module testbench
  import jbs_pkg::*;
;
  localparam logic [3:0]  T_VER  = 4'h6;     // arbitrary
  localparam logic [3:0]  T_UVER = 4'h9;     // arbitrary
  localparam logic [15:0] T_FAM  = 16'h3C5A; // arbitrary
  localparam logic [15:0] T_PART = 16'hC3A5; // arbitrary
  localparam logic [10:0] T_MFR  = 11'h1B3;  // arbitrary
  logic         ref_clk, resetn, trst_n, tck, tms, tdi, tdo, tdo_oe_n, test_hold;
  logic         clk_en;
  logic [39:0]  pin_in, core_in, core_out, pin_out, pin_out_oe_n;
  logic [26:0]  core_bd_o, core_bd_oe_n, core_bd_i, pin_bd_i, pin_bd_o, pin_bd_oe_n;
  logic [199:0] q, pre;
  int           err_count = 0;
  int           cmp_count = 0;
  jbs_host_model jbs_host_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n));
  jbs_tap #(.ID_VERSION(T_VER), .USR_VERSION(T_UVER), .FAMILY_ID(T_FAM), .PART_NUM(T_PART),
    .MFR_ID(T_MFR)) jbs_tap_inst (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .tck(tck), .trst_n(trst_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in),
    .core_in(core_in), .core_out(core_out), .pin_out(pin_out), .pin_out_oe_n(pin_out_oe_n),
    .core_bd_o(core_bd_o), .core_bd_oe_n(core_bd_oe_n), .core_bd_i(core_bd_i),
    .pin_bd_i(pin_bd_i), .pin_bd_o(pin_bd_o), .pin_bd_oe_n(pin_bd_oe_n),
    .test_hold(test_hold));
  task automatic sc(input logic ir, input int n, input logic [199:0] d);
    jbs_host_model_inst.scan(ir, n, d, q);
  endtask
  task automatic edge1();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [199:0] got, input logic [199:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [199:0] cells(input logic [39:0] a, b, input logic [26:0] i, o, c);
    logic [199:0] v;
    v = {120'h0, b, a};
    for (int k = 0; k < 27; k++) begin
      v[80+3*k+:3] = {c[k], o[k], i[k]};
    end
    return v;
  endfunction
  // loads a code, then one captured zero leads the shifted pattern by one stage
  task automatic byp(input logic [5:0] code);
    sc(1'b1, 6, {194'h0, code});
    sc(1'b0, 8, 200'hB4);
    check(q[7:0], 8'h68);
  endtask
  task automatic t_id();
    sc(1'b0, 32, 200'h0);
    check(q[31:0], {T_VER, T_FAM, T_MFR, ID_LSB_ONE});
    sc(1'b1, 6, {194'h0, OP_USERCODE});
    check(q[5:0], IR_CAPTURE);
    sc(1'b0, 32, 200'h0);
    check(q[31:0], {T_UVER, T_PART, T_MFR, ID_LSB_ONE});
    sc(1'b1, 0, 200'h0);
    sc(1'b0, 32, 200'h0);
    check(q[31:0], {T_VER, T_FAM, T_MFR, ID_LSB_ONE});
    $display("done: identification");
  endtask
  task automatic t_bypass();
    byp(OP_BYPASS);
    // reserved codes are probed for the bypass path alone
    byp(6'h15);
    byp(6'h3E);
    $display("done: bypass");
  endtask
  task automatic t_pins();
    logic [199:0] snap;
    pre = cells(40'h0123456789, 40'hFEDCBA9876, 27'h2AAAAAA, 27'h1555555, 27'h0F0F0F0);
    sc(1'b1, 6, {194'h0, OP_SAMPLE});
    snap = cells(pin_in, core_out, pin_bd_i, core_bd_o, core_bd_oe_n);
    sc(1'b0, 161, pre);
    check(q[160:0], snap[160:0]);
    check(pin_out, core_out);
    sc(1'b1, 6, {194'h0, OP_EXTEST});
    check({pin_out, pin_bd_o, pin_bd_oe_n}, {40'hFEDCBA9876, 27'h1555555, 27'h0F0F0F0});
    edge1();
    pin_in = ~pin_in;
    sc(1'b0, 161, pre);
    check(q[39:0], pin_in);
    check(test_hold, 1'b1);
    byp(OP_CLAMP);
    edge1();
    core_out = ~core_out;
    edge1();
    check(pin_out, 40'hFEDCBA9876);
    byp(OP_HIGHZ);
    check({pin_out_oe_n, pin_bd_oe_n}, {67{1'b1}});
    byp(OP_BYPASS);
    repeat (12) edge1();
    check({pin_out, pin_out_oe_n, pin_bd_o, pin_bd_oe_n, test_hold},
          {core_out, 40'h0, core_bd_o, core_bd_oe_n, 1'b0});
    $display("done: pins");
  endtask
  task automatic t_trst();
    byp(OP_HIGHZ);
    edge1();
    trst_n = 1'b0;
    edge1();
    check({pin_out_oe_n, tdo_oe_n}, {40'h0, 1'b1});
    trst_n = 1'b1;
    jbs_host_model_inst.reset_tap();
    sc(1'b0, 32, 200'h0);
    check(q[31:0], {T_VER, T_FAM, T_MFR, ID_LSB_ONE});
    $display("done: tap reset");
  endtask
  // a frozen tap must ignore an empty instruction scan that would reload idcode
  task automatic t_freeze();
    byp(OP_BYPASS);
    edge1();
    clk_en = 1'b0;
    repeat (3) jbs_host_model_inst.tick(1'b0, 1'b0, 1'b0);
    sc(1'b1, 0, 200'h0);
    edge1();
    clk_en = 1'b1;
    repeat (3) jbs_host_model_inst.tick(1'b0, 1'b0, 1'b0);
    sc(1'b0, 8, 200'hB4);
    check(q[7:0], 8'h68);
    $display("done: clock enable");
  endtask
  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    resetn = 1'b0;
    trst_n = 1'b0;
    clk_en = 1'b1;
    pin_in = 40'hA512345678;
    core_out = 40'h3C0F0FF0C3;
    pin_bd_i = 27'h5A5A5A5;
    core_bd_o = 27'h2F0F0F0;
    core_bd_oe_n = 27'h1234567;
    repeat (10) edge1();
    resetn = 1'b1;
    trst_n = 1'b1;
    jbs_host_model_inst.reset_tap();
    t_id();
    t_bypass();
    t_pins();
    t_trst();
    t_freeze();
    check(jbs_host_model_inst.oe_err, 0);
    report_and_stop();
  end
  // whole run needs about 9.5 us of link traffic
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule
bind jbs_tap jbs_monitor #(.N_IN(N_IN), .N_OUT(N_OUT), .N_BIDIR(N_BIDIR)) jbs_monitor_inst (
  .ref_clk(ref_clk), .resetn(resetn), .tck(tck), .trst_n(trst_n), .tms(tms), .tdo(tdo),
  .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_in(core_in), .pin_out_oe_n(pin_out_oe_n),
  .pin_bd_i(pin_bd_i), .core_bd_i(core_bd_i), .pin_bd_oe_n(pin_bd_oe_n),
  .test_hold(test_hold));
